/* File: inc/pwh_consts.svh */
// Purpose: Offsets, field positions and codes of the header encapsulator
// Assumes: Included by bare name after the package
// Notes:   Definitions only
`ifndef PWH_CONSTS_SVH
`define PWH_CONSTS_SVH
// =====================================================================
// Register byte offsets
`define PWH_OFS_CTRL      8'h00
`define PWH_OFS_BUNDLE    8'h04
`define PWH_OFS_TUN0      8'h08
`define PWH_OFS_TUN1      8'h0C
`define PWH_OFS_INNER     8'h10
`define PWH_OFS_COOKIE_LO 8'h14
`define PWH_OFS_COOKIE_HI 8'h18
`define PWH_OFS_STATUS    8'h1C
// =====================================================================
// Control register fields
`define PWH_CTRL_ENC_LO   0
`define PWH_CTRL_ENC_HI   1
`define PWH_CTRL_TUN_LO   2
`define PWH_CTRL_TUN_HI   3
`define PWH_CTRL_CK_LO    4
`define PWH_CTRL_CK_HI    5
`define PWH_CTRL_LOSS     8
`define PWH_CTRL_RBIT     9
// =====================================================================
// Status register fields
`define PWH_STS_BUSY      0
`define PWH_STS_ZERR      1
`define PWH_STS_MATCH     2
`define PWH_STS_CNT_LO    8
`define PWH_STS_CNT_HI    15
// =====================================================================
// Header field positions and codes
`define PWH_LBL_LO        12
`define PWH_LBL_HI        31
`define PWH_SBIT          8
`define PWH_INNER_W       12
`define PWH_CW_LBIT       27
`define PWH_CW_RBIT       26
`define PWH_L2TP_PROTO    8'h73
`define PWH_CK_NONE       2'h0
`define PWH_CK_32         2'h1
`define PWH_CK_64         2'h2
`define PWH_ZERO32        32'h0000_0000
`endif

/* File: inc/pwh_pkg.sv */
// Purpose: Types of the pseudowire header encapsulator
// Assumes: Nothing
// Notes:   State is one packed struct
package pwh_pkg;
  // =====================================================================
  // Encapsulations and header steps
  typedef enum logic [1:0] {PWH_MPLS, PWH_MEF, PWH_L2TP4, PWH_L2TP6} pwh_encap_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TUN, ST_INNER, ST_ECID, ST_SESS, ST_COOKIE, ST_CW
  } pwh_step_t;
  // =====================================================================
  // Bus carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pwh_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pwh_apb_rsp_t;
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [31:0] word;
  } pwh_hdr_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] session;
    logic [63:0] cookie;
  } pwh_rx_t;
  // =====================================================================
  // Configuration and state
  typedef struct packed {
    pwh_encap_t  encap;
    logic [1:0]  tun_cnt;
    logic [1:0]  cookie_mode;
    logic        loss;
    logic        tx_rbit;
    logic [31:0] bundle_id;
    logic [31:0] tun0;
    logic [31:0] tun1;
    logic [11:0] inner;
    logic [31:0] cookie_lo;
    logic [31:0] cookie_hi;
  } pwh_cfg_t;
  typedef struct packed {
    pwh_step_t step;
    logic      idx;
  } pwh_pos_t;
  typedef struct packed {
    pwh_cfg_t    cfg;
    pwh_pos_t    pos;
    logic [31:0] word;
    logic [7:0]  proto;
    logic        ipv6;
    logic        zero_err;
    logic        rx_done;
    logic        rx_match;
    logic [7:0]  mis_cnt;
    logic [31:0] prdata;
  } pwh_state_t;
endpackage

/* File: rtl/pwh_header_encapsulator.sv */
// Purpose: Builds pseudowire headers and checks L2TPv3 arrivals
// Assumes: One bundle configuration, APB register access
// Notes:   Zero wait-state APB, header words leave on a valid/ready stream
`timescale 1ns/10ps
`default_nettype none
`include "pwh_consts.svh"

// Notes on behaviour
// - Zero, one or two tunnel labels precede
// - Tunnel labels S clear, inner label S set
// - Inner label holds bundle id, stack bottom
// - MEF circuit id carries bundle id
// - IPv4 protocol field is L2TPv3 code
// - IPv6 next header is L2TPv3 code
// - Session id is bundle id, zero refused
// - Optional 32 or 64 bit cookie follows
// - Receiver checks cookie against bundle
// - Control word reserved bits sent zero
// - Local fault bit copies port loss
// - Remote fail bit copies bundle setting
module pwh_header_encapsulator
  import pwh_pkg::*;
#(
  parameter int MAX_TUN = 2
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Register bus
  input  wire pwh_apb_req_t apb_req_in,
  output var  pwh_apb_rsp_t apb_rsp_out,
  // Transmit header request and stream
  input  wire logic         tx_start_in,
  input  wire logic         hdr_ready_in,
  output var  pwh_hdr_t     hdr_out,
  output logic [7:0]        ip_proto_out,
  output logic              ip_v6_out,
  // Receive check
  input  wire pwh_rx_t      rx_in,
  output logic              rx_done_out,
  output logic              rx_match_out
);

  // =====================================================================
  // Parameter check
  generate
    if (MAX_TUN < 0 || MAX_TUN > 2) begin : g_bad
      $error("MAX_TUN must lie between 0 and 2");
    end
  endgenerate

  localparam logic [1:0] MAX_TUN_C = 2'(MAX_TUN);

  pwh_state_t st;
  pwh_state_t next_st;

  // =====================================================================
  // Header sequencing
  // Tunnel count clamped to what the stack can hold
  function automatic logic [1:0] eff_tun(input pwh_cfg_t c);
    eff_tun = (c.tun_cnt > MAX_TUN_C) ? MAX_TUN_C : c.tun_cnt;
  endfunction

  // First word of a header for the configured encapsulation
  function automatic pwh_pos_t first_pos(input pwh_cfg_t c);
    first_pos.idx = 1'b0;
    unique case (c.encap)
      PWH_MPLS:  first_pos.step = (eff_tun(c) != 2'h0) ? ST_TUN : ST_INNER;
      PWH_MEF:   first_pos.step = ST_ECID;
      PWH_L2TP4: first_pos.step = ST_SESS;
      PWH_L2TP6: first_pos.step = ST_SESS;
    endcase
  endfunction

  // Word that follows the current one
  function automatic pwh_pos_t next_pos(input pwh_pos_t p, input pwh_cfg_t c);
    next_pos.idx  = 1'b0;
    next_pos.step = ST_IDLE;
    unique case (p.step)
      ST_IDLE: next_pos.step = ST_IDLE;
      ST_TUN: begin
        if (!p.idx && eff_tun(c) > 2'h1) begin
          next_pos.step = ST_TUN;
          next_pos.idx  = 1'b1;
        end else begin
          next_pos.step = ST_INNER;
        end
      end
      ST_INNER: next_pos.step = ST_CW;
      ST_ECID:  next_pos.step = ST_CW;
      // Code 3 carries no cookie, like code 0
      ST_SESS: begin
        if (c.cookie_mode == `PWH_CK_32 || c.cookie_mode == `PWH_CK_64) begin
          next_pos.step = ST_COOKIE;
        end else begin
          next_pos.step = ST_CW;
        end
      end
      ST_COOKIE: begin
        if (!p.idx && c.cookie_mode == `PWH_CK_64) begin
          next_pos.step = ST_COOKIE;
          next_pos.idx  = 1'b1;
        end else begin
          next_pos.step = ST_CW;
        end
      end
      ST_CW: next_pos.step = ST_IDLE;
    endcase
  endfunction

  // Contents of one header word
  function automatic logic [31:0] word_of(input pwh_pos_t p, input pwh_cfg_t c);
    logic [31:0] w;
    w = `PWH_ZERO32;
    unique case (p.step)
      ST_IDLE: w = `PWH_ZERO32;
      ST_TUN: begin
        w = p.idx ? c.tun1 : c.tun0;
        w[`PWH_SBIT] = 1'b0;
      end
      ST_INNER: begin
        w[`PWH_LBL_HI:`PWH_LBL_LO] = c.bundle_id[`PWH_LBL_HI-`PWH_LBL_LO:0];
        w[`PWH_INNER_W-1:0] = c.inner;
        w[`PWH_SBIT] = 1'b1;
      end
      ST_ECID: w[`PWH_LBL_HI:`PWH_LBL_LO] = c.bundle_id[`PWH_LBL_HI-`PWH_LBL_LO:0];
      ST_SESS: w = c.bundle_id;
      ST_COOKIE: begin
        if (c.cookie_mode == `PWH_CK_64 && !p.idx) begin
          w = c.cookie_hi;
        end else begin
          w = c.cookie_lo;
        end
      end
      ST_CW: begin
        w = `PWH_ZERO32;
        w[`PWH_CW_LBIT] = c.loss;
        w[`PWH_CW_RBIT] = c.tx_rbit;
      end
    endcase
    word_of = w;
  endfunction

  // Cookie comparison for the configured length
  function automatic logic cookie_ok(input logic [63:0] ck, input pwh_cfg_t c);
    unique case (c.cookie_mode)
      `PWH_CK_32: cookie_ok = (ck[31:0] == c.cookie_lo);
      `PWH_CK_64: cookie_ok = (ck == {c.cookie_hi, c.cookie_lo});
      default:    cookie_ok = 1'b1;
    endcase
  endfunction

  // =====================================================================
  // Register read mux
  function automatic logic [31:0] read_of(input logic [7:0] a, input pwh_state_t s);
    logic [31:0] r;
    r = `PWH_ZERO32;
    unique case (a)
      `PWH_OFS_CTRL: begin
        r[`PWH_CTRL_ENC_HI:`PWH_CTRL_ENC_LO] = s.cfg.encap;
        r[`PWH_CTRL_TUN_HI:`PWH_CTRL_TUN_LO] = s.cfg.tun_cnt;
        r[`PWH_CTRL_CK_HI:`PWH_CTRL_CK_LO]   = s.cfg.cookie_mode;
        r[`PWH_CTRL_LOSS] = s.cfg.loss;
        r[`PWH_CTRL_RBIT] = s.cfg.tx_rbit;
      end
      `PWH_OFS_BUNDLE:    r = s.cfg.bundle_id;
      `PWH_OFS_TUN0:      r = s.cfg.tun0;
      `PWH_OFS_TUN1:      r = s.cfg.tun1;
      `PWH_OFS_INNER:     r[`PWH_INNER_W-1:0] = s.cfg.inner;
      `PWH_OFS_COOKIE_LO: r = s.cfg.cookie_lo;
      `PWH_OFS_COOKIE_HI: r = s.cfg.cookie_hi;
      `PWH_OFS_STATUS: begin
        r[`PWH_STS_BUSY]  = (s.pos.step != ST_IDLE);
        r[`PWH_STS_ZERR]  = s.zero_err;
        r[`PWH_STS_MATCH] = s.rx_match;
        r[`PWH_STS_CNT_HI:`PWH_STS_CNT_LO] = s.mis_cnt;
      end
      default: r = `PWH_ZERO32;
    endcase
    read_of = r;
  endfunction

  // Decode of mapped offsets
  function automatic logic mapped(input logic [7:0] a);
    unique case (a)
      `PWH_OFS_CTRL, `PWH_OFS_BUNDLE, `PWH_OFS_TUN0, `PWH_OFS_TUN1,
      `PWH_OFS_INNER, `PWH_OFS_COOKIE_LO, `PWH_OFS_COOKIE_HI,
      `PWH_OFS_STATUS: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  endfunction

  // =====================================================================
  // Bus strobes
  logic     apb_setup;
  logic     apb_access;
  logic     apb_wr;
  logic     start_ok;
  logic     zero_refuse;
  logic     l2tp_mode;
  logic     rx_ok;
  pwh_pos_t adv_pos;

  assign apb_setup   = apb_req_in.psel && !apb_req_in.penable;
  assign apb_access  = apb_req_in.psel && apb_req_in.penable;
  assign apb_wr      = apb_access && apb_req_in.pwrite && mapped(apb_req_in.paddr);
  assign l2tp_mode   = (st.cfg.encap == PWH_L2TP4) || (st.cfg.encap == PWH_L2TP6);
  // Zero session id never sent
  assign zero_refuse = tx_start_in && (st.pos.step == ST_IDLE) && l2tp_mode
                       && (st.cfg.bundle_id == `PWH_ZERO32);
  assign start_ok    = tx_start_in && (st.pos.step == ST_IDLE) && !zero_refuse;
  assign adv_pos     = next_pos(st.pos, st.cfg);
  // Arrival must name the bundle and carry its cookie
  assign rx_ok       = (rx_in.session == st.cfg.bundle_id)
                       && (rx_in.session != `PWH_ZERO32)
                       && cookie_ok(rx_in.cookie, st.cfg);

  // =====================================================================
  // Next state
  always_comb begin
    next_st = st;
    // Register writes
    if (apb_wr) begin
      unique case (apb_req_in.paddr)
        `PWH_OFS_CTRL: begin
          next_st.cfg.encap =
            pwh_encap_t'(apb_req_in.pwdata[`PWH_CTRL_ENC_HI:`PWH_CTRL_ENC_LO]);
          next_st.cfg.tun_cnt     = apb_req_in.pwdata[`PWH_CTRL_TUN_HI:`PWH_CTRL_TUN_LO];
          next_st.cfg.cookie_mode = apb_req_in.pwdata[`PWH_CTRL_CK_HI:`PWH_CTRL_CK_LO];
          next_st.cfg.loss        = apb_req_in.pwdata[`PWH_CTRL_LOSS];
          next_st.cfg.tx_rbit     = apb_req_in.pwdata[`PWH_CTRL_RBIT];
        end
        `PWH_OFS_BUNDLE:    next_st.cfg.bundle_id = apb_req_in.pwdata;
        `PWH_OFS_TUN0:      next_st.cfg.tun0      = apb_req_in.pwdata;
        `PWH_OFS_TUN1:      next_st.cfg.tun1      = apb_req_in.pwdata;
        `PWH_OFS_INNER:     next_st.cfg.inner     = apb_req_in.pwdata[`PWH_INNER_W-1:0];
        `PWH_OFS_COOKIE_LO: next_st.cfg.cookie_lo = apb_req_in.pwdata;
        `PWH_OFS_COOKIE_HI: next_st.cfg.cookie_hi = apb_req_in.pwdata;
        `PWH_OFS_STATUS: begin
          if (apb_req_in.pwdata[`PWH_STS_ZERR]) begin
            next_st.zero_err = 1'b0;
          end
          if (apb_req_in.pwdata[`PWH_STS_CNT_LO]) begin
            next_st.mis_cnt = 8'h00;
          end
        end
        default: next_st.cfg = st.cfg;
      endcase
    end
    // Read data captured in the setup cycle
    if (apb_setup) begin
      next_st.prdata = read_of(apb_req_in.paddr, st);
    end
    // Refused start, set wins over clear
    if (zero_refuse) begin
      next_st.zero_err = 1'b1;
    end
    // Header start and advance
    if (start_ok) begin
      next_st.pos  = first_pos(st.cfg);
      next_st.word = word_of(first_pos(st.cfg), st.cfg);
    end else if (st.pos.step != ST_IDLE && hdr_ready_in) begin
      next_st.pos  = adv_pos;
      next_st.word = word_of(adv_pos, st.cfg);
    end
    // IP protocol code for L2TPv3 carriage
    next_st.proto = l2tp_mode ? `PWH_L2TP_PROTO : 8'h00;
    next_st.ipv6  = (st.cfg.encap == PWH_L2TP6);
    // Receive check
    next_st.rx_done = rx_in.valid;
    if (rx_in.valid) begin
      next_st.rx_match = rx_ok;
      if (!rx_ok && st.mis_cnt != 8'hFF) begin
        next_st.mis_cnt = st.mis_cnt + 8'h01;
      end
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================================
  // Outputs
  assign apb_rsp_out.prdata  = st.prdata;
  assign apb_rsp_out.pready  = apb_access;
  assign apb_rsp_out.pslverr = apb_access && !mapped(apb_req_in.paddr);
  assign hdr_out.valid       = (st.pos.step != ST_IDLE);
  assign hdr_out.last        = (st.pos.step == ST_CW);
  assign hdr_out.word        = st.word;
  assign ip_proto_out        = st.proto;
  assign ip_v6_out           = st.ipv6;
  assign rx_done_out         = st.rx_done;
  assign rx_match_out        = st.rx_match;

endmodule
`default_nettype wire

/* File: sim/pwh_header_encapsulator_sva.sv */
// Purpose: Port checks of the header encapsulator
// Assumes: Config is written only between headers
// Notes:   Shadows CTRL and BUNDLE writes
`timescale 1ns/10ps
`default_nettype none
`include "pwh_consts.svh"
module pwh_header_encapsulator_chk
  import pwh_pkg::*;
#(
  parameter int MAX_TUN = 2
) (
  // Clock and reset
  input wire logic         sys_clk_in,
  input wire logic         rst_in,
  // Observed ports
  input wire pwh_apb_req_t apb_req_in,
  input wire pwh_apb_rsp_t apb_rsp_out,
  input wire logic         tx_start_in,
  input wire logic         hdr_ready_in,
  input wire pwh_hdr_t     hdr_out,
  input wire logic [7:0]   ip_proto_out,
  input wire logic         ip_v6_out,
  input wire pwh_rx_t      rx_in,
  input wire logic         rx_done_out,
  input wire logic         rx_match_out
);
  // =====================
  // Shadow config and word index
  logic [1:0]  enc;
  logic [1:0]  tun;
  logic        los;
  logic        rfl;
  logic [31:0] bid;
  logic [2:0]  idx;
  logic        wr_go;
  logic [31:0] wd;
  assign wr_go = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
  assign wd = apb_req_in.pwdata;
  // Track writes and accepted words
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      {enc, tun, los, rfl, bid, idx} <= '0;
    end else begin
      if (wr_go && apb_req_in.paddr == `PWH_OFS_CTRL) begin
        enc <= wd[1:0];
        tun <= (wd[3:2] > MAX_TUN) ? MAX_TUN[1:0] : wd[3:2];
        los <= wd[8];
        rfl <= wd[9];
      end
      if (wr_go && apb_req_in.paddr == `PWH_OFS_BUNDLE) begin
        bid <= wd;
      end
      if (hdr_out.valid && hdr_ready_in) begin
        idx <= hdr_out.last ? 3'h0 : idx + 3'h1;
      end
    end
  end
  // =====================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_stack_count: assert property (hdr_out.valid && hdr_out.last && enc == 2'h0
    |-> idx == {1'b0, tun} + 3'h1) else $error("label count wrong");
  chk_outer_sbit: assert property (hdr_out.valid && enc == 2'h0 && idx < {1'b0, tun}
    |-> !hdr_out.word[8]) else $error("tunnel label marks stack bottom");
  chk_inner_bottom: assert property (hdr_out.valid && enc == 2'h0 && idx == {1'b0, tun}
    |-> hdr_out.word[8] && hdr_out.word[31:12] == bid[19:0] && !hdr_out.last)
    else $error("inner label wrong");
  chk_ecid_field: assert property (hdr_out.valid && enc == 2'h1 && idx == 3'h0
    |-> hdr_out.word == {bid[19:0], 12'h000}) else $error("circuit id wrong");
  chk_v4_proto: assert property (enc[1] && $stable(enc)
    |-> ip_proto_out == 8'h73) else $error("protocol code wrong");
  chk_v6_next: assert property ($stable(enc)
    |-> ip_v6_out == (enc == 2'h3)) else $error("ipv6 flag wrong");
  chk_session_id: assert property (hdr_out.valid && enc[1] && idx == 3'h0
    |-> hdr_out.word == bid && bid != 32'h0) else $error("session id wrong");
  chk_rx_answer: assert property (1'b1
    |=> rx_done_out == $past(rx_in.valid)) else $error("receive answer late");
  chk_cw_reserved: assert property (hdr_out.valid && hdr_out.last
    |-> (hdr_out.word & 32'hF3FF_FFFF) == 32'h0) else $error("reserved bits set");
  chk_cw_flags: assert property (hdr_out.valid && hdr_out.last
    |-> hdr_out.word[27] == los && hdr_out.word[26] == rfl) else $error("fault flags wrong");
endmodule

bind pwh_header_encapsulator pwh_header_encapsulator_chk #(.MAX_TUN(MAX_TUN)) i_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .tx_start_in(tx_start_in), .hdr_ready_in(hdr_ready_in),
  .hdr_out(hdr_out), .ip_proto_out(ip_proto_out), .ip_v6_out(ip_v6_out),
  .rx_in(rx_in), .rx_done_out(rx_done_out), .rx_match_out(rx_match_out));
`default_nettype wire

/* File: sim/pwh_far_end.sv */
// Purpose: Remote pseudowire endpoint model
// Assumes: Header words are taken on ready
// Notes:   Slow mode halves the take rate
`timescale 1ns/10ps
`default_nettype none
module pwh_far_end
  import pwh_pkg::*;
(
  // Clock and reset
  input wire logic  clk_in,
  input wire logic  rst_in,
  // Header sink
  input wire logic  slow_in,
  input wire pwh_hdr_t hdr_in,
  output logic      ready_out,
  // Arriving L2TPv3 fields
  output pwh_rx_t   rx_out
);
  logic [31:0] got [$];
  initial rx_out = '0;
  // Ready pattern, stalls every other cycle when slow
  always @(posedge clk_in) begin
    ready_out <= rst_in ? 1'b0 : (slow_in ? ~ready_out : 1'b1);
    if (hdr_in.valid && ready_out) begin
      got.push_back(hdr_in.word);
    end
  end
  // One arrival, fields inverted once released
  task automatic send(input logic [31:0] s, input logic [63:0] c);
    @(posedge clk_in) rx_out <= '{1'b1, s, c};
    @(posedge clk_in) rx_out <= '{1'b0, ~s, ~c};
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the header encapsulator
// Assumes: Zero wait APB, far end model on the stream
// Notes:   One task per scenario
`timescale 1ns/10ps
`default_nettype none
`include "pwh_consts.svh"
module tb
  import pwh_pkg::*;
;
  // =====================
  // Signals and values
  localparam logic [31:0] BID = 32'h000A_BCDE;
  localparam logic [31:0] TN0 = 32'h1234_5F3C;
  localparam logic [31:0] TN1 = 32'h6789_A1FF;
  localparam logic [31:0] INR = 32'h0000_0E40;
  localparam logic [31:0] CKL = 32'h5A5A_0F0F;
  localparam logic [31:0] CKH = 32'hC3C3_9696;
  logic         sys_clk_in;
  logic         rst_in;
  pwh_apb_req_t apb_req;
  pwh_apb_rsp_t apb_rsp;
  logic         tx_start;
  logic         hdr_ready;
  pwh_hdr_t     hdr;
  logic [7:0]   ip_proto;
  logic         ip_v6;
  pwh_rx_t      rx;
  logic         rx_done;
  logic         rx_match;
  logic         slow;
  logic [31:0]  rdv;
  logic         erv;
  logic [31:0]  exp_q [$];
  int           err_total;
  int           comparisons;
  // Device and far end
  pwh_header_encapsulator #(.MAX_TUN(2)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .apb_req_in(apb_req),
    .apb_rsp_out(apb_rsp), .tx_start_in(tx_start), .hdr_ready_in(hdr_ready),
    .hdr_out(hdr), .ip_proto_out(ip_proto), .ip_v6_out(ip_v6),
    .rx_in(rx), .rx_done_out(rx_done), .rx_match_out(rx_match));
  pwh_far_end i_far (.clk_in(sys_clk_in), .rst_in(rst_in), .slow_in(slow),
    .hdr_in(hdr), .ready_out(hdr_ready), .rx_out(rx));
  // =====================
  // Shared tasks
  task check_val(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in) apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk_in) apb_req.penable <= 1'b1;
    do @(posedge sys_clk_in); while (apb_rsp.pready !== 1'b1);
    rdv = apb_rsp.prdata;
    erv = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  function automatic logic [31:0] cw(input logic l, input logic r);
    return {4'h0, l, r, 26'h0};
  endfunction
  task run_hdr;
    int n;
    i_far.got.delete();
    @(posedge sys_clk_in) tx_start <= 1'b1;
    @(posedge sys_clk_in) tx_start <= 1'b0;
    n = 0;
    while (i_far.got.size() < exp_q.size() && n < 100) begin
      @(posedge sys_clk_in);
      n++;
    end
    repeat (8) @(posedge sys_clk_in);
    check_val(i_far.got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < i_far.got.size()) check_val(i_far.got[i], exp_q[i]);
  endtask
  // =====================
  // Scenarios
  task sc_regs;
    apb(1'b0, `PWH_OFS_CTRL, 32'h0);
    check_val(rdv, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check_val({erv, rdv}, {1'b1, 32'h0});
    apb(1'b1, `PWH_OFS_BUNDLE, BID);
    apb(1'b1, `PWH_OFS_TUN0, TN0);
    apb(1'b1, `PWH_OFS_TUN1, TN1);
    apb(1'b1, `PWH_OFS_INNER, INR);
    apb(1'b1, `PWH_OFS_COOKIE_LO, CKL);
    apb(1'b1, `PWH_OFS_COOKIE_HI, CKH);
    apb(1'b0, `PWH_OFS_BUNDLE, 32'h0);
    check_val(rdv, BID);
  endtask
  task sc_mpls;
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, `PWH_OFS_CTRL, {22'h0, t[0], ~t[0], 4'h0, t[1:0], 2'h0});
      exp_q = {};
      if (t > 0) exp_q.push_back(TN0 & 32'hFFFF_FEFF);
      if (t > 1) exp_q.push_back(TN1 & 32'hFFFF_FEFF);
      exp_q.push_back({BID[19:0], INR[11:0] | 12'h100});
      exp_q.push_back(cw(~t[0], t[0]));
      slow = (t == 2);
      run_hdr;
      check_val(ip_proto, 8'h00);
    end
    slow = 1'b0;
  endtask
  task sc_mef;
    apb(1'b1, `PWH_OFS_CTRL, 32'h0000_0301);
    exp_q = '{{BID[19:0], 12'h000}, cw(1'b1, 1'b1)};
    run_hdr;
  endtask
  task sc_l2tp;
    for (int m = 2; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, `PWH_OFS_CTRL, {26'h0, k[1:0], 2'h2, m[1:0]});
        exp_q = '{BID};
        if (k == 2) exp_q.push_back(CKH);
        if (k == 1 || k == 2) exp_q.push_back(CKL);
        exp_q.push_back(cw(1'b0, 1'b0));
        slow = k[0];
        run_hdr;
        check_val({ip_v6, ip_proto}, {m == 3, 8'h73});
      end
    end
    slow = 1'b0;
  endtask
  task sc_zero;
    apb(1'b1, `PWH_OFS_BUNDLE, 32'h0);
    apb(1'b1, `PWH_OFS_CTRL, 32'h0000_0002);
    exp_q = {};
    run_hdr;
    apb(1'b0, `PWH_OFS_STATUS, 32'h0);
    check_val(rdv[1], 1'b1);
    apb(1'b1, `PWH_OFS_BUNDLE, BID);
  endtask
  task rx_try(input logic [31:0] s, input logic [63:0] c, input logic m);
    i_far.send(s, c);
    @(negedge sys_clk_in);
    check_val({rx_done, rx_match}, {1'b1, m});
  endtask
  task sc_rx;
    apb(1'b1, `PWH_OFS_CTRL, 32'h0000_0022);
    rx_try(BID, {CKH, CKL}, 1'b1);
    rx_try(BID, {CKH, ~CKL}, 1'b0);
    apb(1'b1, `PWH_OFS_CTRL, 32'h0000_0012);
    rx_try(BID, {~CKH, CKL}, 1'b1);
    rx_try(BID + 32'h1, {CKH, CKL}, 1'b0);
  endtask
  // Software raises remote fail after misses, clears on arrival
  task sc_rfail;
    apb(1'b0, `PWH_OFS_STATUS, 32'h0);
    check_val(rdv[15:0], 16'h0202);
    apb(1'b1, `PWH_OFS_CTRL, 32'h0000_0201);
    exp_q = '{{BID[19:0], 12'h000}, cw(1'b0, 1'b1)};
    run_hdr;
    apb(1'b1, `PWH_OFS_STATUS, 32'h0000_0102);
    apb(1'b0, `PWH_OFS_STATUS, 32'h0);
    check_val(rdv[15:0], 16'h0000);
    rx_try(BID, {CKH, CKL}, 1'b1);
    apb(1'b1, `PWH_OFS_CTRL, 32'h0000_0001);
  endtask
  // =====================
  // Clock, watchdog and main sequence
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial begin
    {apb_req, tx_start, slow, err_total, comparisons} = '0;
    rst_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    sc_regs;
    sc_mpls;
    sc_mef;
    sc_l2tp;
    sc_zero;
    sc_rx;
    sc_rfail;
    give_verdict;
  end
endmodule
`default_nettype wire
